//--- dv/ssc_core_assertions.sv
// Pin-level checks for the clock-stop serial port in master mode
`timescale 1ns/1ns
module ssc_core_chk #(
  parameter int TURNON_CYC = 4
) (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [1:0] clock_stop_field,
  input wire logic       tx_clock_polarity,
  input wire logic       tx_clock_direction,
  input wire logic       output_turnon_delay_en,
  input wire logic       rx_data_valid,
  input wire logic       tx_serial_clock_o,
  input wire logic       tx_serial_clock_oe,
  input wire logic       tx_frame_sync_o,
  input wire logic       serial_data_out_o,
  input wire logic       serial_data_out_oe
);
  logic       mst;
  logic [7:0] low_q;
  logic [4:0] edg_q;
  assign mst = clock_stop_field[1] & tx_clock_direction;

  // Cycles since select went low, saturating
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      low_q <= 8'h00;
    else if (tx_frame_sync_o)
      low_q <= 8'h00;
    else if (low_q != 8'hff)
      low_q <= low_q + 8'h01;

  // Pin clock edges seen while selected
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      edg_q <= 5'h00;
    else if (tx_frame_sync_o)
      edg_q <= 5'h00;
    else if (tx_serial_clock_o != $past(tx_serial_clock_o))
      edg_q <= edg_q + 5'h01;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence ss_fall_s;
    mst && $fell(tx_frame_sync_o);
  endsequence
  sequence ss_rise_s;
    mst && $rose(tx_frame_sync_o) && $stable(clock_stop_field);
  endsequence

  clk_dir_a: assert property (
    tx_serial_clock_oe == tx_clock_direction)
    else $error("clock driver does not follow direction");
  idle_level_a: assert property (
    mst && tx_frame_sync_o && $stable(clock_stop_field)
    && $stable(tx_clock_polarity) |-> tx_serial_clock_o == tx_clock_polarity)
    else $error("pin clock not idle between transfers");
  no_spi_data_a: assert property (
    !clock_stop_field[1] |-> !serial_data_out_oe)
    else $error("data driver on outside clock stop mode");
  select_first_a: assert property (
    ss_fall_s |-> tx_serial_clock_o == tx_clock_polarity)
    else $error("clock edge together with select fall");
  edge_count_a: assert property (
    ss_rise_s |-> edg_q == 5'd16)
    else $error("frame without sixteen clock edges");
  turnon_hold_a: assert property (
    mst && !tx_frame_sync_o && output_turnon_delay_en
    && low_q < TURNON_CYC |-> !serial_data_out_oe)
    else $error("data driver on before turn-on delay");
  turnon_on_a: assert property (
    mst && !tx_frame_sync_o && $stable(clock_stop_field)
    && (!output_turnon_delay_en || low_q >= TURNON_CYC)
    |-> serial_data_out_oe)
    else $error("data driver off inside frame");
  drive_edge_a: assert property (
    mst && !tx_frame_sync_o && $stable(tx_frame_sync_o)
    && $changed(serial_data_out_o) |-> tx_serial_clock_o ==
    (tx_clock_polarity ^ !clock_stop_field[0]))
    else $error("data changed on the sampling edge");
  rx_pulse_a: assert property (
    rx_data_valid |=> !rx_data_valid)
    else $error("receive strobe longer than one cycle");
endmodule : ssc_core_chk

//--- dv/ssc_slave_model.sv
// Behavioural SPI slave facing the port
`timescale 1ns/1ns
module ssc_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       pol,
  input  wire logic       early,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  int i;
  initial
  begin
    miso = 1'b0;
    rx_byte = 8'h00;
    i = 0;
  end
  always @(negedge ss_n)
  begin
    i = 0;
    if (early)
      miso = tx_byte[7];
  end
  // released line does not keep its level
  always @(posedge ss_n)
    miso = ~miso;
  always @(sck)
    if (!ss_n)
    begin
      if ((sck != pol) == early)
        rx_byte = {rx_byte[6:0], mosi};
      else
      begin
        if (early)
          i++;
        if (i < 8)
          miso = tx_byte[7-i];
        if (!early)
          i++;
      end
    end
endmodule : ssc_slave_model

//--- dv/tb_top.sv
// Bench: master-mode traffic through the clock-stop serial port
`timescale 1ns/1ns
module tb_top;
  import ssc_pkg::*;
  localparam int TON = 2;
  logic       mclk, reset_n, pol, dly, src, ext, vld, last;
  logic       rdy, rv, sck_o, sck_oe, fs_o, fs_oe, dat_o, dat_oe;
  logic       miso, mosi, sck, ss_n;
  logic [1:0] csf;
  ssc_div_t   div;
  logic [7:0] txd, rxd, mtx, mrx;
  int         checked, fail_count, n;
  assign sck  = sck_oe ? sck_o : pol;
  assign ss_n = fs_oe ? fs_o : 1'b1;
  // Released data line shows the inverse, never a stale level
  assign mosi = dat_oe ? dat_o : ~dat_o;

  // clock and sync pins driven as outputs
  // no loopback, one element, fixed delays
  ssc_core #(.TURNON_CYC(TON)) dut (
    .mclk(mclk), .reset_n(reset_n), .clock_stop_field(csf),
    .tx_clock_polarity(pol), .tx_clock_direction(1'b1),
    .tx_sync_direction(1'b1), .output_turnon_delay_en(dly),
    .rate_gen_clock_source(src), .rate_gen_divider(div),
    .frame_period_field(12'h003), .frame_width_field(8'h01),
    .tx_data_valid(vld), .tx_data_ready(rdy), .tx_data(txd),
    .rx_data_valid(rv), .rx_data(rxd), .external_clock_in(ext),
    .tx_serial_clock_i(sck), .tx_serial_clock_o(sck_o),
    .tx_serial_clock_oe(sck_oe), .tx_frame_sync_i(ss_n),
    .tx_frame_sync_o(fs_o), .tx_frame_sync_oe(fs_oe),
    .serial_data_out_o(dat_o), .serial_data_out_oe(dat_oe),
    .serial_data_in(miso));
  ssc_slave_model far (.sck(sck), .ss_n(ss_n), .mosi(mosi), .pol(pol),
    .early(csf[0]), .tx_byte(mtx), .miso(miso), .rx_byte(mrx));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(negedge mclk)
    ext <= ~ext;

  task automatic summarize();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic lost();
    chk(8'hff, 8'h00);
    summarize();
  endtask : lost

  task automatic push(input logic [7:0] w);
    int k;
    k = 0;
    vld = 1'b1;
    txd = w;
    while (rdy !== 1'b1 && k < 800)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 800)
      lost();
    @(negedge mclk);
  endtask : push

  // Waits for one received word and the end of its frame
  task automatic take(input logic [7:0] w);
    int k;
    k = 0;
    while (rv !== 1'b1 && k < 800)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 800)
      lost();
    chk(rxd, mtx);
    chk(mrx, w);
    while (fs_o !== 1'b1 && k < 900)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 900)
      lost();
    @(negedge mclk);
  endtask : take

  initial
  begin
    checked = 0;
    fail_count = 0;
    reset_n = 1'b0;
    csf = 2'b10;
    pol = 1'b0;
    dly = 1'b0;
    src = 1'b1;
    ext = 1'b0;
    vld = 1'b0;
    txd = 8'h00;
    mtx = 8'h00;
    div = 8'h03;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    chk({4'h0, dat_oe, fs_o, rdy, rv}, 8'h06);
    $display("test reset done");
    for (int m = 0; m < 4; m++)
    begin
      csf = {1'b1, m[0]};
      pol = m[1];
      dly = m[0] ^ m[1];
      mtx = 8'hc5 - 8'(m);
      push(8'h3c + 8'(m));
      vld = 1'b0;
      take(8'h3c + 8'(m));
    end
    $display("test modes done");
    csf = 2'b10;
    pol = 1'b0;
    mtx = 8'h5a;
    for (int m = 0; m < 5; m++)
      push(8'h10 + 8'(m));
    vld = 1'b0;
    chk({7'h00, rdy}, 8'h00);
    for (int m = 0; m < 5; m++)
      take(8'h10 + 8'(m));
    $display("test burst done");
    src = 1'b0;
    mtx = 8'h81;
    push(8'h7e);
    vld = 1'b0;
    take(8'h7e);
    src = 1'b1;
    $display("test external clock done");
    csf = 2'b00;
    @(negedge mclk);
    last = sck_o;
    n = 0;
    repeat (20)
    begin
      @(negedge mclk);
      if (sck_o !== last)
        n++;
      last = sck_o;
    end
    chk(8'(n), 8'h05);
    $display("test continuous done");
    summarize();
  end
endmodule : tb_top

bind ssc_core ssc_core_chk #(.TURNON_CYC(TURNON_CYC)) chk_i (
  .mclk(mclk), .reset_n(reset_n), .clock_stop_field(clock_stop_field),
  .tx_clock_polarity(tx_clock_polarity),
  .tx_clock_direction(tx_clock_direction),
  .output_turnon_delay_en(output_turnon_delay_en),
  .rx_data_valid(rx_data_valid), .tx_serial_clock_o(tx_serial_clock_o),
  .tx_serial_clock_oe(tx_serial_clock_oe),
  .tx_frame_sync_o(tx_frame_sync_o), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe(serial_data_out_oe));

//--- inc/ssc_pkg.sv
// Types shared by the clock-stop serial port modules
package ssc_pkg;

  // Master sequence, Gray coded along idle-lead-shift-trail
  typedef enum logic [1:0] {
    SSC_IDLE  = 2'b00,
    SSC_LEAD  = 2'b01,
    SSC_SHIFT = 2'b11,
    SSC_TRAIL = 2'b10
  } ssc_state_e;

  typedef logic [7:0] ssc_div_t;

endpackage : ssc_pkg

//--- inc/ssc_regs.svh
// Constant macros for the clock-stop serial port
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// Clock stop field codes; bit 1 set means SPI mode, bit 0 the delayed format
`define SSC_STOP_BIT       1
`define SSC_PHASE_BIT      0
`define SSC_STOP_NODLY     2'b10
`define SSC_STOP_DLY       2'b11

// Reset values
`define SSC_DIV_RST        8'h01
`define SSC_DOUT_RST       1'b0
`define SSC_SS_IDLE        1'b1

// Extra cycles the data driver stays off when turn-on delay is enabled
`define SSC_TURNON_CYC     4

// Default widths and FIFO depth
`define SSC_DATA_W         8
`define SSC_FIFO_DEPTH     4
`define SSC_FRAME_PERIOD_FIELD_W         12
`define SSC_FRAME_WIDTH_FIELD_W         8

`endif

//--- inc/ssc_stream_if.sv
// Valid/ready word stream between the port's own modules
`timescale 1ns/1ns
interface ssc_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ssc_stream_if

//--- verilog/ssc_core.sv
// Clock-stop serial port: SPI master/slave with data turn-on delay
`timescale 1ns/1ns
`include "ssc_regs.svh"
module ssc_core #(
  parameter int DATA_W     = `SSC_DATA_W,
  parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH,
  parameter int FRAME_PERIOD_FIELD_W     = `SSC_FRAME_PERIOD_FIELD_W,
  parameter int FRAME_WIDTH_FIELD_W     = `SSC_FRAME_WIDTH_FIELD_W,
  parameter int TURNON_CYC = `SSC_TURNON_CYC
) (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [1:0]        clock_stop_field,
  input  wire logic              tx_clock_polarity,
  input  wire logic              tx_clock_direction,
  input  wire logic              tx_sync_direction,
  input  wire logic              output_turnon_delay_en,
  input  wire logic              rate_gen_clock_source,
  input  wire ssc_pkg::ssc_div_t rate_gen_divider,
  input  wire logic [FRAME_PERIOD_FIELD_W-1:0] frame_period_field,
  input  wire logic [FRAME_WIDTH_FIELD_W-1:0] frame_width_field,
  input  wire logic              tx_data_valid,
  output logic                   tx_data_ready,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic                   rx_data_valid,
  output logic [DATA_W-1:0]      rx_data,
  input  wire logic              external_clock_in,
  input  wire logic              tx_serial_clock_i,
  output logic                   tx_serial_clock_o,
  output logic                   tx_serial_clock_oe,
  input  wire logic              tx_frame_sync_i,
  output logic                   tx_frame_sync_o,
  output logic                   tx_frame_sync_oe,
  output logic                   serial_data_out_o,
  output logic                   serial_data_out_oe,
  input  wire logic              serial_data_in
);
  import ssc_pkg::*;

  localparam int CW = $clog2(DATA_W);
  localparam int TW = $clog2(TURNON_CYC + 1);

  ssc_stream_if #(.W(DATA_W)) wr_s ();
  ssc_stream_if #(.W(DATA_W)) rd_s ();

  ssc_state_e        state_q;
  logic              half_tick;
  logic              clkg_q;
  logic              edge_par_q;
  logic [CW-1:0]     trail_cnt_q;
  logic [CW-1:0]     rx_cnt_q;
  logic [DATA_W-1:0] shreg_q;
  logic [DATA_W-2:0] rxsh_q;
  logic              dout_q;
  logic              ss_n_q;
  logic              sck_prev_q;
  logic              ss_prev_q;
  logic [TW-1:0]     don_cnt_q;
  logic [FRAME_PERIOD_FIELD_W-1:0] fcnt_q;
  logic              fs_q;
  logic              spi;
  logic              cph;
  logic              pol;
  logic              master;
  logic              m_start;
  logic              s_start;
  logic              start;
  logic              lead_ev;
  logic              trail_ev;
  logic              drive_ev;
  logic              sample_ev;
  logic              drive_win;
  logic              slv_sel;
  logic [DATA_W-1:0] load_word;

  assign spi    = clock_stop_field[`SSC_STOP_BIT];
  assign cph    = clock_stop_field[`SSC_PHASE_BIT];
  assign pol    = tx_clock_polarity;
  assign master = tx_clock_direction;

  // Transmit words wait here; full FIFO stalls the writer
  assign wr_s.valid    = tx_data_valid;
  assign wr_s.data     = tx_data;
  assign tx_data_ready = wr_s.ready;

  ssc_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk    (mclk),
    .reset_n (reset_n),
    .in_s    (wr_s),
    .out_s   (rd_s)
  );

  ssc_rate_gen u_rate (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .src_cpu   (rate_gen_clock_source),
    .divider   (rate_gen_divider),
    .ext_clk   (external_clock_in),
    .half_tick (half_tick)
  );

  assign slv_sel = ~master & ~tx_frame_sync_i;

  assign m_start = spi & master & half_tick & (state_q == SSC_IDLE)
                   & rd_s.valid;
  assign s_start = spi & slv_sel & ss_prev_q;
  assign start   = m_start | s_start;
  // A slave with nothing queued answers with zeros rather than stalling
  assign rd_s.ready = start;
  assign load_word  = rd_s.valid ? rd_s.data : '0;

  always_comb
  begin
    if (master)
    begin
      lead_ev  = half_tick & (state_q == SSC_SHIFT) & ~edge_par_q;
      trail_ev = half_tick & (state_q == SSC_SHIFT) & edge_par_q;
    end
    else
    begin
      lead_ev  = spi & slv_sel & (sck_prev_q == pol)
                 & (tx_serial_clock_i != pol);
      trail_ev = spi & slv_sel & (sck_prev_q != pol)
                 & (tx_serial_clock_i == pol);
    end
  end

  assign drive_ev  = cph ? trail_ev : lead_ev;
  assign sample_ev = cph ? lead_ev : trail_ev;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      clkg_q <= 1'b0;
    else if (half_tick)
      clkg_q <= ~clkg_q;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_prev_q <= 1'b0;
      ss_prev_q  <= `SSC_SS_IDLE;
    end
    else
    begin
      sck_prev_q <= tx_serial_clock_i;
      ss_prev_q  <= tx_frame_sync_i;
    end
  end

  // Master sequence: lead half-bit, 2*DATA_W edges, trail half-bit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q     <= SSC_IDLE;
      edge_par_q  <= 1'b0;
      trail_cnt_q <= '0;
      ss_n_q      <= `SSC_SS_IDLE;
    end
    else
    begin
      unique case (state_q)
        SSC_IDLE:
        begin
          if (m_start)
          begin
            state_q <= SSC_LEAD;
            ss_n_q  <= 1'b0;
          end
        end
        SSC_LEAD:
        begin
          if (half_tick)
          begin
            state_q     <= SSC_SHIFT;
            edge_par_q  <= 1'b0;
            trail_cnt_q <= '0;
          end
        end
        SSC_SHIFT:
        begin
          if (half_tick)
          begin
            edge_par_q <= ~edge_par_q;
            if (edge_par_q)
            begin
              trail_cnt_q <= trail_cnt_q + CW'(1);
              if (trail_cnt_q == CW'(DATA_W - 1))
                state_q <= SSC_TRAIL;
            end
          end
        end
        SSC_TRAIL:
        begin
          if (half_tick)
          begin
            state_q <= SSC_IDLE;
            ss_n_q  <= `SSC_SS_IDLE;
          end
        end
      endcase
      // Leaving SPI mode or master role abandons a transfer in flight
      if (!spi || !master)
      begin
        state_q    <= SSC_IDLE;
        ss_n_q     <= `SSC_SS_IDLE;
        edge_par_q <= 1'b0;
      end
    end
  end

  // Transmit shifter, MSB first
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shreg_q <= '0;
      dout_q  <= `SSC_DOUT_RST;
    end
    else if (start)
    begin
      if (cph)
      begin
        dout_q  <= load_word[DATA_W-1];
        shreg_q <= {load_word[DATA_W-2:0], 1'b0};
      end
      else
        shreg_q <= load_word;
    end
    else if (drive_ev)
    begin
      dout_q  <= shreg_q[DATA_W-1];
      shreg_q <= {shreg_q[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_cnt_q      <= '0;
      rxsh_q        <= '0;
      rx_data       <= '0;
      rx_data_valid <= 1'b0;
    end
    else
    begin
      rx_data_valid <= 1'b0;
      if (start)
        rx_cnt_q <= '0;
      else if (sample_ev)
      begin
        rxsh_q <= {rxsh_q[DATA_W-3:0], serial_data_in};
        if (rx_cnt_q == CW'(DATA_W - 1))
        begin
          rx_data       <= {rxsh_q, serial_data_in};
          rx_data_valid <= 1'b1;
          rx_cnt_q      <= '0;
        end
        else
          rx_cnt_q <= rx_cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fcnt_q <= '0;
      fs_q   <= 1'b0;
    end
    else if (spi)
    begin
      fcnt_q <= '0;
      fs_q   <= 1'b0;
    end
    else if (half_tick && !clkg_q)
    begin
      fcnt_q <= (fcnt_q == frame_period_field) ? '0 : fcnt_q + FRAME_PERIOD_FIELD_W'(1);
      fs_q   <= (fcnt_q <= FRAME_PERIOD_FIELD_W'(frame_width_field));
    end
  end

  // Data driver window: master from select low, slave while selected
  assign drive_win = spi & (master ? (state_q != SSC_IDLE) : slv_sel);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      don_cnt_q <= '0;
    else if (!drive_win)
      don_cnt_q <= '0;
    else if (don_cnt_q != TW'(TURNON_CYC))
      don_cnt_q <= don_cnt_q + TW'(1);
  end

  assign serial_data_out_oe = drive_win
                              & (~output_turnon_delay_en
                                 | (don_cnt_q == TW'(TURNON_CYC)));
  assign serial_data_out_o  = dout_q;

  assign tx_serial_clock_o  = spi ? (pol ^ edge_par_q) : (pol ^ clkg_q);
  assign tx_serial_clock_oe = master;
  assign tx_frame_sync_o    = spi ? ss_n_q : fs_q;
  assign tx_frame_sync_oe   = tx_sync_direction;

endmodule : ssc_core

//--- verilog/ssc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module ssc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  ssc_stream_if.snk in_s,
  ssc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign in_s.ready  = (cnt_q != (AW + 1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rd_q];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= ptr_inc(wr_q);
      if (pop)
        rd_q <= ptr_inc(rd_q);
      if (push && !pop)
        cnt_q <= cnt_q + (AW + 1)'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - (AW + 1)'(1);
    end
  end
endmodule : ssc_fifo

//--- verilog/ssc_rate_gen.sv
// Sample rate generator: half-bit ticks from CPU or external clock
`timescale 1ns/1ns
module ssc_rate_gen (
  input  wire logic            mclk,
  input  wire logic            reset_n,
  input  wire logic            src_cpu,
  input  wire ssc_pkg::ssc_div_t divider,
  input  wire logic            ext_clk,
  output logic                 half_tick
);
  import ssc_pkg::*;

  ssc_div_t cnt_q;
  logic     ext_prev_q;
  logic     step;

  // External clock counts on its rising edges, CPU clock on every cycle
  assign step      = src_cpu | (ext_clk & ~ext_prev_q);
  assign half_tick = step & (cnt_q == divider);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q      <= '0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_prev_q <= ext_clk;
      if (half_tick)
        cnt_q <= '0;
      else if (step)
        cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : ssc_rate_gen
